// ===== t16cw_defines.svh
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * 16-bit timer compare and waveform block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef T16CW_DEFINES_SVH
`define T16CW_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define T16CW_ADR_CTRL    5'h00
`define T16CW_ADR_COUNT   5'h04
`define T16CW_ADR_CMPA    5'h08
`define T16CW_ADR_CMPB    5'h0c
`define T16CW_ADR_CAPT    5'h10
`define T16CW_ADR_FLAGS   5'h14
`define T16CW_ADR_FORCE   5'h18

// ----------------------------------------
// Control fields
// ----------------------------------------
`define T16CW_F_WGM       3:0
`define T16CW_F_COMA      5:4
`define T16CW_F_COMB      7:6
`define T16CW_F_PRE       10:8
`define T16CW_B_DIRA      11
`define T16CW_B_DIRB      12
`define T16CW_B_PORTA     13
`define T16CW_B_PORTB     14
`define T16CW_CTRL_RST    15'h0000

// ----------------------------------------
// Flag bits
// ----------------------------------------
`define T16CW_B_OVF       0
`define T16CW_B_MFA       1
`define T16CW_B_MFB       2
`define T16CW_B_CAPF      3

// ----------------------------------------
// Counter constants and prescaler masks
// ----------------------------------------
`define T16CW_MAX         16'hffff
`define T16CW_TOP8        16'h00ff
`define T16CW_TOP9        16'h01ff
`define T16CW_TOP10       16'h03ff
`define T16CW_DIV8_M      10'h007
`define T16CW_DIV64_M     10'h03f
`define T16CW_DIV256_M    10'h0ff
`define T16CW_DIV1024_M   10'h3ff

`endif

// ===== t16cw_pkg.sv
/*
 * Types of the 16-bit timer compare and waveform block.
 * Assumes the defines header is included by the design file.
 */
package t16cw_pkg;
  typedef logic [15:0] t16cw_cnt_t;
  typedef logic [3:0]  t16cw_wgm_t;
  typedef logic [1:0]  t16cw_com_t;
  typedef enum logic [2:0] {
    T16CW_PRE_STOP = 3'h0,
    T16CW_PRE_1    = 3'h1,
    T16CW_PRE_8    = 3'h2,
    T16CW_PRE_64   = 3'h3,
    T16CW_PRE_256  = 3'h4,
    T16CW_PRE_1024 = 3'h5
  } t16cw_pre_t;
endpackage

// ===== t16cw_top.sv
/*
 * 16-bit timer: counter, two compare channels with waveform outputs,
 * compare-match blocking, force strobes and flags, behind classic Wishbone.
 * Assumes one 40 MHz clock, synchronous active-high reset, and an
 * outside pad that builds the pin from the data and enable outputs.
 */
// Implementation choices: the register addresses and register access over Wishbone.
// How it works
// - A counter write blocks every compare match in the next timer tick.
// - Output state keeps its value across waveform mode changes.
// - Output action field is unbuffered and acts at once.
// - Reset clears the output state to zero.
// - Nonzero action field puts the waveform on the pin; direction stays.
// - Action field never touches the capture register or capture flag.
// - Action field zero leaves output state unchanged on matches.
// - New action applies from next match; force applies at once non-PWM.
// - Counting follows only the mode field; action picks set/clear/toggle.
// - Mode 0 counts up without clear, wrapping 0xffff to zero.
// - Overflow flag set on the wrap from 0xffff and on the fast PWM clear at top; only hardware sets it.
// - Modes 4 and 12 clear the counter on match with A or capture top.
// - Clear-on-match raises A flag or capture flag at top.
// - Unbuffered top below count lets the counter run past 0xffff.
// - Toggle action in mode 4 gives clk/(2N(1+A)) on output A.
// - Prescaler divides by 1, 8, 64, 256 or 1024.
// - Clear-on-match mode sets overflow when rolling from max to zero.
// - Modes 5,6,7,14,15 count single slope from bottom to top.
// - Fast PWM: non-inverting set on match, clear at top; inverting reverse.
// - Counter equal to compare sets its flag at the next timer clock edge.
// - PWM modes buffer compare writes, loaded only at fast PWM top; others direct.
// - Force updates output like a match, no flag, no counter change.
`timescale 1ns/1ps
`include "t16cw_defines.svh"

module t16cw_top
(
  input  wire logic                 clk_i,             // System clock, 40 MHz
  input  wire logic                 rst_i,             // Sync reset, high
  input  wire logic                 cyc_i,             // Wishbone cycle
  input  wire logic                 stb_i,             // Wishbone strobe
  input  wire logic                 we_i,              // Wishbone write
  input  wire logic [4:0]           adr_i,             // Byte address
  input  wire logic [3:0]           sel_i,             // Byte enables
  input  wire logic [31:0]          dat_i,             // Write data
  output logic      [31:0]          dat_o,             // Read data
  output logic                      ack_o,             // Acknowledge
  output t16cw_pkg::t16cw_cnt_t     count_value_o,     // Counter state
  output logic                      compare_out_a_o,   // Pin A data
  output logic                      compare_out_a_oe_o,// Pin A enable
  output logic                      compare_out_b_o,   // Pin B data
  output logic                      compare_out_b_oe_o // Pin B enable
);
  import t16cw_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [14:0] ctrl_ff;
  t16cw_cnt_t  cnt_ff;
  t16cw_cnt_t  cmp_act_ff [2];
  t16cw_cnt_t  cmp_buf_ff [2];
  t16cw_cnt_t  capture_value_ff;
  logic [3:0]  flag_ff;
  logic        blk_ff;
  logic [9:0]  pre_ff;
  logic [1:0]  oc_ff;
  logic [1:0]  pin_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire        req_w   = cyc_i & stb_i & ~ack_ff;
  wire        wr_w    = req_w & we_i;
  wire [31:0] bmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire        wr_ctrl = wr_w & (adr_i == `T16CW_ADR_CTRL);
  wire        wr_cnt  = wr_w & (adr_i == `T16CW_ADR_COUNT);
  wire        wr_cmpa = wr_w & (adr_i == `T16CW_ADR_CMPA);
  wire        wr_cmpb = wr_w & (adr_i == `T16CW_ADR_CMPB);
  wire        wr_capt = wr_w & (adr_i == `T16CW_ADR_CAPT);
  wire        wr_flag = wr_w & (adr_i == `T16CW_ADR_FLAGS);
  wire        wr_frc  = wr_w & (adr_i == `T16CW_ADR_FORCE);
  wire [15:0] m16_w   = bmask_w[15:0];
  wire [15:0] d16_w   = dat_i[15:0];

  wire t16cw_wgm_t wgm_w = ctrl_ff[`T16CW_F_WGM];
  wire t16cw_com_t com_w [2];
  assign com_w[0] = ctrl_ff[`T16CW_F_COMA];
  assign com_w[1] = ctrl_ff[`T16CW_F_COMB];
  wire [2:0] pre_sel_w = ctrl_ff[`T16CW_F_PRE];

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Free divider shared by all ratios; a ratio change may shorten one period.
  wire        run_w  = (pre_sel_w != T16CW_PRE_STOP) && (pre_sel_w <= T16CW_PRE_1024);
  wire [9:0]  pmask_w = (pre_sel_w == T16CW_PRE_8)    ? `T16CW_DIV8_M   :
                        (pre_sel_w == T16CW_PRE_64)   ? `T16CW_DIV64_M  :
                        (pre_sel_w == T16CW_PRE_256)  ? `T16CW_DIV256_M :
                        (pre_sel_w == T16CW_PRE_1024) ? `T16CW_DIV1024_M : 10'h000;
  wire        tick_w = run_w & ((pre_ff & pmask_w) == pmask_w);

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire normal_w = (wgm_w == 4'h0);
  wire ctc_w    = (wgm_w == 4'h4) | (wgm_w == 4'hc);
  wire fast_w   = (wgm_w == 4'h5) | (wgm_w == 4'h6) | (wgm_w == 4'h7)
                | (wgm_w == 4'he) | (wgm_w == 4'hf);
  wire pwm_w    = ~normal_w & ~ctc_w;
  wire icr_top  = (wgm_w == 4'hc) | (wgm_w == 4'he);
  wire oca_top  = (wgm_w == 4'h4) | (wgm_w == 4'hf);
  wire t16cw_cnt_t top_w = oca_top ? cmp_act_ff[0] :
                           icr_top ? capture_value_ff :
                           (wgm_w == 4'h5) ? `T16CW_TOP8 :
                           (wgm_w == 4'h6) ? `T16CW_TOP9 :
                           (wgm_w == 4'h7) ? `T16CW_TOP10 : `T16CW_MAX;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Top is compared by equality only, so a top written below the count is
  // passed and the counter runs through the 16-bit wrap first.
  wire        at_top_w = (cnt_ff == top_w) & ~blk_ff;
  wire        clr_w    = tick_w & (ctc_w | fast_w) & at_top_w;
  wire        wrap_w   = tick_w & (cnt_ff == `T16CW_MAX);
  wire        ovf_set  = wrap_w | (clr_w & fast_w);
  wire [15:0] nxt_cnt  = wr_cnt ? ((cnt_ff & ~m16_w) | (d16_w & m16_w)) :
                         clr_w  ? 16'h0000 :
                         tick_w ? 16'(cnt_ff + 16'h0001) : cnt_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 16'h0000;
      blk_ff <= 1'b0;
      pre_ff <= 10'h000;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      blk_ff <= wr_cnt | (blk_ff & ~tick_w);
      pre_ff <= run_w ? 10'(pre_ff + 10'h001) : 10'h000;
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  logic [1:0] mt_w;
  logic [1:0] frc_w;
  logic [1:0] nxt_oc;
  logic [1:0] wr_cmp_w;
  assign wr_cmp_w = {wr_cmpb, wr_cmpa};

  for (genvar x = 0; x < 2; x++)
  begin : g_ch
    wire t16cw_cnt_t nxt_buf = (cmp_buf_ff[x] & ~m16_w) | (d16_w & m16_w);
    assign mt_w[x]  = tick_w & (cnt_ff == cmp_act_ff[x]) & ~blk_ff;
    assign frc_w[x] = wr_frc & sel_i[0] & dat_i[x] & ~pwm_w;
    wire   tgl_ok   = (x == 0) & (wgm_w == 4'hf);
    // Action field is read live each cycle, never staged.
    always_comb
    begin
      nxt_oc[x] = oc_ff[x];
      if (com_w[x] == 2'h0)
        nxt_oc[x] = oc_ff[x];
      else if (~pwm_w)
      begin
        if (mt_w[x] | frc_w[x])
        begin
          unique case (com_w[x])
            2'h1:    nxt_oc[x] = ~oc_ff[x];
            2'h2:    nxt_oc[x] = 1'b0;
            default: nxt_oc[x] = 1'b1;
          endcase
        end
      end
      else if (fast_w)
      begin
        // Match wins over top, so compare equal to top gives a constant level, except the toggle on A in mode 15.
        if (mt_w[x])
          nxt_oc[x] = (com_w[x] == 2'h1) ? (tgl_ok ? ~oc_ff[x] : oc_ff[x]) :
                      (com_w[x] == 2'h2);
        else if (clr_w)
          nxt_oc[x] = (com_w[x] == 2'h1) ? oc_ff[x] : (com_w[x] == 2'h3);
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cmp_act_ff[x] <= 16'h0000;
        cmp_buf_ff[x] <= 16'h0000;
      end
      else
      begin
        if (wr_cmp_w[x])
          cmp_buf_ff[x] <= nxt_buf;
        if (wr_cmp_w[x] & ~pwm_w)
          cmp_act_ff[x] <= nxt_buf;
        else if (fast_w & clr_w)
          cmp_act_ff[x] <= cmp_buf_ff[x];
      end
    end
  end

  // ----------------------------------------
  // Output state and pins
  // ----------------------------------------
  // Mode writes never touch the output state; only reset, matches, fast PWM top and force change it.
  wire [1:0] ovr_w  = {com_w[1] != 2'h0, com_w[0] != 2'h0};
  wire [1:0] port_w = {ctrl_ff[`T16CW_B_PORTB], ctrl_ff[`T16CW_B_PORTA]};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oc_ff  <= 2'b00;
      pin_ff <= 2'b00;
    end
    else
    begin
      oc_ff  <= nxt_oc;
      pin_ff <= (ovr_w & oc_ff) | (~ovr_w & port_w);
    end
  end
  assign compare_out_a_o    = pin_ff[0];
  assign compare_out_b_o    = pin_ff[1];
  assign compare_out_a_oe_o = ctrl_ff[`T16CW_B_DIRA];
  assign compare_out_b_oe_o = ctrl_ff[`T16CW_B_DIRB];
  assign count_value_o      = cnt_ff;

  // ----------------------------------------
  // Flags, control and capture value
  // ----------------------------------------
  // Set beats a clear written in the same cycle.
  wire [3:0] fset_w = {clr_w & icr_top, mt_w[1], mt_w[0], ovf_set};
  wire [3:0] fclr_w = {4{wr_flag & sel_i[0]}} & dat_i[3:0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff          <= `T16CW_CTRL_RST;
      flag_ff          <= 4'h0;
      capture_value_ff <= 16'h0000;
    end
    else
    begin
      flag_ff <= fset_w | (flag_ff & ~fclr_w);
      if (wr_ctrl)
        ctrl_ff <= (ctrl_ff & ~bmask_w[14:0]) | (dat_i[14:0] & bmask_w[14:0]);
      if (wr_capt)
        capture_value_ff <= (capture_value_ff & ~m16_w) | (d16_w & m16_w);
    end
  end

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  wire [31:0] rd_w = (adr_i == `T16CW_ADR_CTRL)  ? {17'h0, ctrl_ff} :
                     (adr_i == `T16CW_ADR_COUNT) ? {16'h0, cnt_ff} :
                     (adr_i == `T16CW_ADR_CMPA)  ? {16'h0, cmp_buf_ff[0]} :
                     (adr_i == `T16CW_ADR_CMPB)  ? {16'h0, cmp_buf_ff[1]} :
                     (adr_i == `T16CW_ADR_CAPT)  ? {16'h0, capture_value_ff} :
                     (adr_i == `T16CW_ADR_FLAGS) ? {28'h0, flag_ff} : 32'h0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req_w;
      dat_ff <= req_w ? rd_w : 32'h0;
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_block_match: assert property (blk_ff && tick_w && !wr_frc |=> oc_ff == $past(oc_ff))
    else $error("match not blocked after counter write");
  chk_block_ends: assert property (wr_cnt ##1 (tick_w && !wr_cnt) |=> !blk_ff)
    else $error("match block outlived one tick");
  chk_reset_out: assert property (disable iff (1'b0) rst_i |=> oc_ff == 2'b00)
    else $error("output state not cleared by reset");
  chk_mode_keep: assert property (wr_ctrl && mt_w == 2'b00 && frc_w == 2'b00 && !clr_w
    |=> $stable(oc_ff))
    else $error("output state changed by a mode write");
  chk_zero_action: assert property (com_w[0] == 2'h0 |=> oc_ff[0] == $past(oc_ff[0]))
    else $error("action zero changed output A");
  chk_pin_source: assert property (ovr_w[0] ##1 ovr_w[0] |-> pin_ff[0] == $past(oc_ff[0]))
    else $error("pin A not driven by waveform");
  chk_normal_wrap: assert property (normal_w && wrap_w && !wr_cnt
    |=> cnt_ff == 16'h0000 && flag_ff[`T16CW_B_OVF])
    else $error("normal mode wrap or overflow wrong");
  chk_ctc_clear: assert property (ctc_w && oca_top && mt_w[0] && !wr_cnt
    |=> cnt_ff == 16'h0000 && flag_ff[`T16CW_B_MFA])
    else $error("clear-on-match did not clear");
  chk_ctc_toggle: assert property (ctc_w && com_w[0] == 2'h1 && mt_w[0]
    |=> oc_ff[0] != $past(oc_ff[0]))
    else $error("toggle on match missing");
  chk_fast_set: assert property (fast_w && com_w[1] == 2'h2 && mt_w[1]
    |=> oc_ff[1])
    else $error("fast PWM did not set on match");
  chk_div8_gap: assert property (tick_w && pre_sel_w == T16CW_PRE_8 && !wr_ctrl
    |=> !tick_w [*7])
    else $error("divide by 8 ticked early");

  cov_ctc_toggle: cover property (ctc_w && com_w[0] == 2'h1 && mt_w[0]);
  cov_fast_top:   cover property (fast_w && clr_w);
  cov_force:      cover property (frc_w[1]);
  cov_blocked:    cover property (blk_ff && tick_w && cnt_ff == cmp_act_ff[0]);
endmodule

// ===== t16cw_top_tb.sv
/*
 * Self-checking bench for the 16-bit timer compare and waveform block.
 * Assumes the defines header and the package are compiled first and that
 * the design answers Wishbone requests one cycle after taking them.
 */
`timescale 1ns/1ps
`include "t16cw_defines.svh"

module t16cw_top_tb;
  import t16cw_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [4:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  t16cw_cnt_t  count_value_o;
  logic        pa;
  logic        pa_oe;
  logic        pb;
  logic        pb_oe;
  int          errors;
  int          num_checks;
  int          cyc_cnt;
  int          n;
  int          last;
  int          ntog;
  logic [31:0] q;
  logic [15:0] prev;
  logic [15:0] hi;
  logic        s;
  logic        old;
  int          divs [5] = '{1, 8, 64, 256, 1024};
  logic [1:0]  acts [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
  logic        exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  t16cw_top u_t16cw_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .count_value_o(count_value_o), .compare_out_a_o(pa), .compare_out_a_oe_o(pa_oe),
    .compare_out_b_o(pb), .compare_out_b_oe_o(pb_oe));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Pins are {port B, port A, dir B, dir A}
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] a,
                                      input logic [1:0] b, input logic [2:0] p,
                                      input logic [3:0] pins);
    return {17'h00000, pins, p, b, a, m};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50)
      chk("ack", 32'h1, 32'h0);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // Output state lands one edge after the cause, the pin one edge later
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  // Samples on the falling edge, where the count has settled; returns the
  // count seen one cycle before the target and the cycles spent waiting
  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    do
    begin
      prev = count_value_o;
      @(negedge clk_i);
      n++;
    end while (count_value_o !== v && n < 3000);
    if (n >= 3000)
      chk("count_wait", {16'h0, v}, {16'h0, count_value_o});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000)
    begin
      errors++;
      $display("[FAIL] run timeout expected 0 seen %0d", cyc_cnt);
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    errors = 0;
    num_checks = 0;
    cyc_cnt = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pin_a_rst", 32'h0, {31'h0, pa});
    rdchk("ctrl_rst", `T16CW_ADR_CTRL, 32'h0);
    rdchk("count_rst", `T16CW_ADR_COUNT, 32'h0);
    wb(1'b1, 5'h1c, 32'h0000ffff);
    rdchk("unmapped", 5'h1c, 32'h0);
    $display("test reset done");

    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h0, 4'h5));
    wb(1'b1, `T16CW_ADR_FORCE, 32'h1);
    settle();
    chk("pin_a_port", 32'h1, {31'h0, pa});
    chk("oe_a", 32'h1, {31'h0, pa_oe});
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h1, 2'h0, 3'h0, 4'h5));
    settle();
    chk("pin_a_state", 32'h0, {31'h0, pa});
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, acts[i], 2'h0, 3'h0, 4'h1));
      wb(1'b1, `T16CW_ADR_FORCE, 32'h1);
      settle();
      chk("pin_a_force", {31'h0, exps[i]}, {31'h0, pa});
    end
    rdchk("flags_force", `T16CW_ADR_FLAGS, 32'h0);
    rdchk("count_force", `T16CW_ADR_COUNT, 32'h0);
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h4, 2'h1, 2'h0, 3'h0, 4'h0));
    settle();
    chk("pin_a_mode", 32'h1, {31'h0, pa});
    chk("oe_a_off", 32'h0, {31'h0, pa_oe});
    $display("test force done");

    // Blocked start, unblocked start, unblocked start with no action
    s = 1'b1;
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h1, 2'h0, 3'h0, 4'h1));
    wb(1'b1, `T16CW_ADR_CMPA, 32'h5);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, `T16CW_ADR_FLAGS, 32'hf);
      wb(1'b1, `T16CW_ADR_COUNT, (i == 0) ? 32'h5 : 32'h4);
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, (i == 2) ? 2'h0 : 2'h1, 2'h0, 3'h1, 4'h1));
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h1, 2'h0, 3'h0, 4'h1));
      settle();
      if (i == 1)
        s = ~s;
      rdchk("flag_a_block", `T16CW_ADR_FLAGS, (i == 0) ? 32'h0 : 32'h2);
      chk("pin_a_block", {31'h0, s}, {31'h0, pa});
    end
    $display("test blocking done");

    wb(1'b1, `T16CW_ADR_CMPA, 32'h8000);
    wb(1'b1, `T16CW_ADR_CMPB, 32'h2000);
    wb(1'b1, `T16CW_ADR_FLAGS, 32'hf);
    wb(1'b1, `T16CW_ADR_COUNT, 32'hfff0);
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h1, 4'h0));
    wait_cnt(16'h0000);
    chk("wrap_from", 32'hffff, {16'h0, prev});
    wait_cnt(16'h0001);
    chk("no_clear", 32'h0, {16'h0, prev});
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h0, 4'h0));
    rdchk("ovf_normal", `T16CW_ADR_FLAGS, 32'h1);
    $display("test normal done");

    for (int m = 4; m <= 12; m += 8)
    begin
      wb(1'b1, `T16CW_ADR_CMPA, (m == 4) ? 32'h3 : 32'h1000);
      wb(1'b1, `T16CW_ADR_CAPT, (m == 12) ? 32'h3 : 32'h1000);
      wb(1'b1, `T16CW_ADR_COUNT, 32'h0);
      wb(1'b1, `T16CW_ADR_FLAGS, 32'hf);
      wb(1'b1, `T16CW_ADR_CTRL, ctl(m[3:0], 2'h1, 2'h0, 3'h1, 4'h1));
      hi = 16'h0;
      ntog = 0;
      last = -1;
      old = pa;
      for (int c = 0; c < 40; c++)
      begin
        @(posedge clk_i);
        if (count_value_o > hi)
          hi = count_value_o;
        if (pa !== old)
        begin
          if (last >= 0)
            chk("toggle_gap", 32'h4, c - last);
          last = c;
          ntog++;
        end
        old = pa;
      end
      wb(1'b1, `T16CW_ADR_CTRL, ctl(m[3:0], 2'h1, 2'h0, 3'h0, 4'h1));
      chk("ctc_top", 32'h3, {16'h0, hi});
      chk("toggled", (m == 4) ? 32'h1 : 32'h0, {31'h0, ntog > 4});
      rdchk("ctc_flags", `T16CW_ADR_FLAGS, (m == 4) ? 32'h2 : 32'h8);
    end
    // Top of 3 written below the count: the counter must wrap before clearing
    wb(1'b1, `T16CW_ADR_COUNT, 32'hfff0);
    wb(1'b1, `T16CW_ADR_FLAGS, 32'hf);
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'hc, 2'h1, 2'h0, 3'h1, 4'h1));
    wait_cnt(16'h0000);
    chk("ctc_wrap", 32'hffff, {16'h0, prev});
    wait_cnt(16'h0000);
    chk("ctc_top_after_wrap", 32'h3, {16'h0, prev});
    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'hc, 2'h1, 2'h0, 3'h0, 4'h1));
    rdchk("ctc_wrap_flags", `T16CW_ADR_FLAGS, 32'h9);
    $display("test clear on match done");

    wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h0, 4'h2));
    wb(1'b1, `T16CW_ADR_CMPB, 32'h10);
    for (int a = 2; a <= 3; a++)
    begin
      wb(1'b1, `T16CW_ADR_COUNT, 32'h0);
      wb(1'b1, `T16CW_ADR_FLAGS, 32'hf);
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h5, 2'h0, a[1:0], 3'h1, 4'h2));
      wait_cnt(16'h00ff);
      wait_cnt(16'h0000);
      chk("fast_top", 32'hff, {16'h0, prev});
      wait_cnt(16'h0008);
      chk("pwm_low", (a == 3) ? 32'h1 : 32'h0, {31'h0, pb});
      wait_cnt(16'h0080);
      chk("pwm_high", (a == 2) ? 32'h1 : 32'h0, {31'h0, pb});
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h5, 2'h0, a[1:0], 3'h0, 4'h2));
      rdchk("fast_flags", `T16CW_ADR_FLAGS, 32'h5);
    end
    $display("test fast pwm done");

    for (int p = 1; p <= 5; p++)
    begin
      wb(1'b1, `T16CW_ADR_COUNT, 32'h0);
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, p[2:0], 4'h0));
      wait_cnt(16'h0001);
      wait_cnt(16'h0002);
      chk("tick_spacing", divs[p - 1], n);
      wb(1'b1, `T16CW_ADR_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h0, 4'h0));
    end
    $display("test prescaler done");
    tally_and_finish();
  end
endmodule
